// ### shared/vd_pkg.sv
// constants and types shared by the decoder stream ports
package vd_pkg;
  // code set rates and lane layout
  localparam int RATE0 = 2;
  localparam int RATE1 = 3;
  localparam int MAX_RATE = 3;
  localparam int LANE_W = 8;
  localparam int SOFT_W = 3;
  localparam int STD_IN_W = LANE_W * MAX_RATE;
  localparam int COSTED_N = 4;
  localparam int COST_W = SOFT_W + 1;
  localparam int SECTOR_W = 4;
  localparam int SECTOR_LSB = 32;
  localparam int DATA_IN_W = 40;
  localparam int DATA_OUT_W = 16;
  localparam int OUT_SECTOR_LSB = 8;
  // sideband words
  localparam int TUSER_W = 8;
  localparam int TU_ERASE_LSB = 0;
  localparam int TU_SEL = 3;
  localparam int TU_BLOCK = 4;
  localparam int TO_SEL = 0;
  localparam int TO_BLOCK = 1;
  localparam int TO_METRIC_RENORM_FLAG = 2;
  localparam int DSTAT_W = 16;
  localparam logic [15:0] WINDOW_RST = 16'h0100;
  // decoder delay and start-up
  localparam int DELAY = 8;
  localparam int FILL_W = 4;
  localparam logic [1:0] READY_CYCLES = 2'h2;
  // multichannel and metrics
  localparam int MAX_CH = 32;
  localparam int CH_W = 5;
  localparam int METRIC_W = 8;
  localparam logic [7:0] RENORM_LIMIT = 8'hc0;
  // delayed word layout
  localparam int W_BIT = 0;
  localparam int W_HARD = 1;
  localparam int W_ACT = W_HARD + MAX_RATE;
  localparam int W_SEL = W_ACT + MAX_RATE;
  localparam int W_BLK = W_SEL + 1;
  localparam int W_SECT = W_BLK + 1;
  localparam int DW = W_SECT + SECTOR_W;
  // register map
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RENORM = 12'h008;
  localparam int C_TRELLIS = 0;
  localparam int C_DUAL = 1;
  localparam int C_HARD = 2;
  localparam int C_MULTI = 3;
  localparam int C_ERASE = 4;
  localparam int C_BLOCK = 5;
  localparam int C_METRIC_RENORM_FLAG = 6;
  localparam int C_CH_LSB = 8;
  localparam int CTRL_W = 13;
  localparam logic [12:0] CTRL_RST = 13'h0001;
  typedef enum logic [3:0] {
    MODE_STD = 4'b0001,
    MODE_DUAL = 4'b0010,
    MODE_TRELLIS = 4'b0100,
    MODE_MULTI = 4'b1000
  } mode_t;
  typedef enum logic [2:0] {
    LIFE_HOLD = 3'b001,
    LIFE_WAIT = 3'b010,
    LIFE_RUN = 3'b100
  } life_t;
endpackage

// ### shared/vd_links_if.sv
// links between the decoder top and its delay line and error monitor
`timescale 1ns/100ps
`default_nettype none
interface delay_link_if;
  logic adv;
  logic [vd_pkg::DW-1:0] din;
  logic [vd_pkg::DW-1:0] dout;
  modport owner(output adv, output din, input dout);
  modport line(input adv, input din, output dout);
endinterface

interface ber_link_if;
  logic sym;
  logic [1:0] errs;
  logic s_valid;
  logic s_ready;
  logic [15:0] s_data;
  logic m_valid;
  logic m_ready;
  logic [15:0] m_data;
  modport owner(output sym, output errs, output s_valid, output s_data,
    input s_ready, input m_valid, input m_data, output m_ready);
  modport mon(input sym, input errs, input s_valid, input s_data,
    output s_ready, output m_valid, output m_data, input m_ready);
endinterface
`default_nettype wire

// ### hw/vd_delay_line.sv
// fixed-depth delay line carrying the decoded bit and its sideband
`timescale 1ns/100ps
`default_nettype none
module vd_delay_line (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // link to the top
  delay_link_if.line lnk
);
  logic [vd_pkg::DW-1:0] stage_r [vd_pkg::DELAY];

  genvar g;
  generate
    for (g = 0; g < vd_pkg::DELAY; g = g + 1) begin : gen_stage
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          stage_r[g] <= '0;
        end else if (lnk.adv) begin
          if (g == 0) begin
            stage_r[g] <= lnk.din;
          end else begin
            stage_r[g] <= stage_r[(g == 0) ? 0 : g - 1];
          end
        end
      end
    end
  endgenerate

  assign lnk.dout = stage_r[vd_pkg::DELAY-1];
endmodule
`default_nettype wire

// ### hw/vd_error_monitor.sv
// windowed error counter with held report handshake
`timescale 1ns/100ps
`default_nettype none
module vd_error_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // link to the top
  ber_link_if.mon lnk
);
  logic [15:0] window_r;
  logic [15:0] cnt_r;
  logic [15:0] acc_r;
  logic s_ready_r;
  logic m_valid_r;
  logic [15:0] m_data_r;
  logic [15:0] acc_sum;
  logic win_end;

  assign acc_sum = acc_r + {14'h0000, lnk.errs};
  assign win_end = lnk.sym && (cnt_r + 16'h0001 >= window_r);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_ready_r <= 1'b0;
      window_r <= vd_pkg::WINDOW_RST;
    end else begin
      s_ready_r <= 1'b1;
      if (lnk.s_valid && s_ready_r) begin
        window_r <= lnk.s_data;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_r <= '0;
      acc_r <= '0;
    end else if (win_end) begin
      cnt_r <= '0;
      acc_r <= '0;
    end else if (lnk.sym) begin
      cnt_r <= cnt_r + 16'h0001;
      acc_r <= (acc_sum < acc_r) ? 16'hffff : acc_sum;
    end
  end

  // a held report is never overwritten; a new one is dropped instead
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      m_valid_r <= 1'b0;
      m_data_r <= '0;
    end else if (win_end && (!m_valid_r || lnk.m_ready)) begin
      m_valid_r <= 1'b1; // RULE_21
      m_data_r <= (acc_sum < acc_r) ? 16'hffff : acc_sum;
    end else if (m_valid_r && lnk.m_ready) begin
      m_valid_r <= 1'b0; // RULE_24
    end
  end

  assign lnk.s_ready = s_ready_r;
  assign lnk.m_valid = m_valid_r;
  assign lnk.m_data = m_data_r;
endmodule
`default_nettype wire

// ### hw/vd_stream_ports.sv
// convolutional decoder stream ports, sideband and register slave
//
// Contract
// [RULE_01] zero fill bits above the symbol fields are ignored by the decoder
// [RULE_02] symbol fields are 1 bit hard or 3 to 5 bits soft
// [RULE_03] non-trellis input word is 8 bits times the output rate
// [RULE_04] dual variant has as many symbol fields as the larger rate
// [RULE_05] trellis costed fields are 4 to 6 bits, soft width plus one
// [RULE_06] trellis takes four costed inputs and decodes as rate 1/2
// [RULE_07] trellis input word is 40 bits, sector in the top byte
// [RULE_08] trellis sector is delayed and returned in the output word
// [RULE_09] input sideband fields are used only when their option is set
// [RULE_10] an erased symbol field is decoded as a null symbol
// [RULE_11] erasure flags have one bit per symbol field, at most 7
// [RULE_12] select low uses code set one, high uses code set two
// [RULE_13] block marker is delayed by decoder latency with its bits
// [RULE_14] sideband words are sized in multiples of 8 bits
// [RULE_15] decoded data is one bit per output transfer
// [RULE_16] output word is 8 bits, or 16 in trellis mode
// [RULE_17] output sideband fields appear only when their option is set
// [RULE_18] select bit is delayed alongside the bits it governed
// [RULE_19] renorm flag marks that path metric normalization happened
// [RULE_20] upstream gives the 16-bit error window length in symbols
// [RULE_21] 16-bit error count from re-encoded output, none in trellis mode
// [RULE_22] multichannel decodes 2 to 32 interleaved channels, one decoder
// [RULE_23] a word moves only when valid and ready are both high
// [RULE_24] error count stays unchanged until the receiver takes it
// [RULE_25] with clock enable low, inputs are ignored and state frozen
// [RULE_26] after reset release the device is ready two enabled cycles later
// [RULE_27] each symbol field sits right-aligned in its own byte lane
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module vd_stream_ports (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // coded symbol stream in
  input wire logic i_s_data_tvalid,
  output logic o_s_data_tready,
  input wire logic [39:0] i_s_data_tdata,
  input wire logic [7:0] i_s_data_tuser,
  // decoded stream out
  output logic o_m_data_tvalid,
  input wire logic i_m_data_tready,
  output logic [15:0] o_m_data_tdata,
  output logic [7:0] o_m_data_tuser,
  // error window in
  input wire logic i_s_dstat_tvalid,
  output logic o_s_dstat_tready,
  input wire logic [15:0] i_s_dstat_tdata,
  // error count out
  output logic o_m_dstat_tvalid,
  input wire logic i_m_dstat_tready,
  output logic [15:0] o_m_dstat_tdata
);
  localparam int R = vd_pkg::MAX_RATE; // RULE_03 RULE_04

  logic [vd_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0] renorm_cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  vd_pkg::life_t life_r;
  logic [1:0] wait_cnt_r;
  logic s_tready_r;
  logic [vd_pkg::FILL_W-1:0] fill_r;
  logic m_tvalid_r;
  logic [15:0] m_tdata_r;
  logic [7:0] m_tuser_r;
  logic metric_renorm_flag_pend_r;
  logic [vd_pkg::CH_W-1:0] ch_r;
  logic [vd_pkg::METRIC_W-1:0] metric_r [vd_pkg::MAX_CH];

  vd_pkg::mode_t mode;
  logic accept;
  logic emit;
  logic apb_acc;
  logic sel_in;
  logic [R-1:0] hard;
  logic [R-1:0] active;
  logic [R-1:0] lane_used;
  logic [1:0] ones;
  logic [1:0] n_act;
  logic bit_dec;
  logic [vd_pkg::METRIC_W-1:0] cost;
  logic [vd_pkg::METRIC_W-1:0] metric_sum;
  logic renorm;
  logic [vd_pkg::COST_W-1:0] tcm_cost [vd_pkg::COSTED_N];
  logic [1:0] tcm_idx;
  logic [vd_pkg::COST_W-1:0] tcm_min;
  logic m_tvalid_nxt;
  logic full_nxt;
  logic [1:0] errs;
  logic [R-1:0] mism;

  delay_link_if dly ();
  ber_link_if error_count_report ();

  vd_delay_line u_delay (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .lnk(dly)
  );

  vd_error_monitor u_ber (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .lnk(error_count_report)
  );

  // mode decode from control
  always_comb begin
    if (ctrl_r[vd_pkg::C_TRELLIS]) begin
      mode = vd_pkg::MODE_TRELLIS;
    end else if (ctrl_r[vd_pkg::C_DUAL]) begin
      mode = vd_pkg::MODE_DUAL;
    end else if (ctrl_r[vd_pkg::C_MULTI]) begin
      mode = vd_pkg::MODE_MULTI;
    end else begin
      mode = vd_pkg::MODE_STD;
    end
  end

  // transfers count only on enabled edges
  assign accept = i_clk_en && i_s_data_tvalid && s_tready_r; // RULE_23
  assign emit = accept && (fill_r == vd_pkg::FILL_W'(vd_pkg::DELAY));
  assign sel_in = (mode == vd_pkg::MODE_DUAL) &&
    i_s_data_tuser[vd_pkg::TU_SEL]; // RULE_09

  // per-lane hard decision and activity
  genvar g;
  generate
    for (g = 0; g < R; g = g + 1) begin : gen_lane
      // low bits of each byte lane only, fill bits never read
      assign hard[g] = ctrl_r[vd_pkg::C_HARD] ?
        i_s_data_tdata[g*vd_pkg::LANE_W] : // RULE_01
        i_s_data_tdata[g*vd_pkg::LANE_W + vd_pkg::SOFT_W - 1]; // RULE_27
      assign lane_used[g] = sel_in ? (g < vd_pkg::RATE1) :
        (g < vd_pkg::RATE0); // RULE_12
      assign active[g] = lane_used[g] && !(ctrl_r[vd_pkg::C_ERASE] &&
        i_s_data_tuser[vd_pkg::TU_ERASE_LSB + g]); // RULE_10 RULE_11
    end
    for (g = 0; g < vd_pkg::COSTED_N; g = g + 1) begin : gen_tcm
      assign tcm_cost[g] =
        i_s_data_tdata[g*vd_pkg::LANE_W +: vd_pkg::COST_W]; // RULE_05
    end
  endgenerate

  // vote over active symbols; trellis picks least costed branch
  always_comb begin
    ones = 2'h0;
    n_act = 2'h0;
    for (int i = 0; i < R; i++) begin
      ones = ones + {1'b0, active[i] & hard[i]};
      n_act = n_act + {1'b0, active[i]};
    end
    tcm_idx = 2'h0;
    tcm_min = tcm_cost[0];
    for (int i = 1; i < vd_pkg::COSTED_N; i++) begin
      if (tcm_cost[i] < tcm_min) begin
        tcm_min = tcm_cost[i];
        tcm_idx = 2'(i);
      end
    end
    if (mode == vd_pkg::MODE_TRELLIS) begin
      bit_dec = tcm_idx[1]; // RULE_06
      cost = {{(vd_pkg::METRIC_W - vd_pkg::COST_W){1'b0}}, tcm_min};
    end else begin
      bit_dec = ({ones, 1'b0} > {1'b0, n_act}); // RULE_02
      cost = bit_dec ? {6'h00, n_act - ones} : {6'h00, ones};
    end
  end

  assign metric_sum = metric_r[ch_r] + cost;
  assign renorm = accept && (metric_sum >= vd_pkg::RENORM_LIMIT);

  // word entering the delay line
  always_comb begin
    dly.din = '0;
    dly.din[vd_pkg::W_BIT] = bit_dec;
    dly.din[vd_pkg::W_HARD +: R] = hard;
    dly.din[vd_pkg::W_ACT +: R] = active;
    dly.din[vd_pkg::W_SEL] = sel_in; // RULE_18
    dly.din[vd_pkg::W_BLK] = ctrl_r[vd_pkg::C_BLOCK] &&
      i_s_data_tuser[vd_pkg::TU_BLOCK]; // RULE_13
    if (mode == vd_pkg::MODE_TRELLIS) begin
      dly.din[vd_pkg::W_SECT +: vd_pkg::SECTOR_W] =
        i_s_data_tdata[vd_pkg::SECTOR_LSB +: vd_pkg::SECTOR_W]; // RULE_07
    end
  end
  assign dly.adv = accept; // RULE_25

  // start-up sequence after reset release
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      life_r <= vd_pkg::LIFE_HOLD;
      wait_cnt_r <= 2'h0;
    end else if (i_clk_en) begin
      case (life_r)
        vd_pkg::LIFE_HOLD: begin
          life_r <= vd_pkg::LIFE_WAIT;
          wait_cnt_r <= 2'h1;
        end
        vd_pkg::LIFE_WAIT: begin
          if (wait_cnt_r == vd_pkg::READY_CYCLES - 2'h1) begin
            life_r <= vd_pkg::LIFE_RUN; // RULE_26
          end else begin
            wait_cnt_r <= wait_cnt_r + 2'h1;
          end
        end
        vd_pkg::LIFE_RUN: begin
          life_r <= vd_pkg::LIFE_RUN;
        end
        default: begin
          life_r <= vd_pkg::LIFE_HOLD;
        end
      endcase
    end
  end

  // input ready only when the output slot can take an emitted bit
  assign m_tvalid_nxt = emit ? 1'b1 :
    (m_tvalid_r && i_m_data_tready) ? 1'b0 : m_tvalid_r;
  assign full_nxt = (fill_r == vd_pkg::FILL_W'(vd_pkg::DELAY)) ||
    (accept && fill_r == vd_pkg::FILL_W'(vd_pkg::DELAY - 1));

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_tready_r <= 1'b0;
    end else if (i_clk_en) begin
      s_tready_r <= (life_r == vd_pkg::LIFE_RUN ||
        (life_r == vd_pkg::LIFE_WAIT &&
        wait_cnt_r == vd_pkg::READY_CYCLES - 2'h1)) &&
        (!full_nxt || !m_tvalid_nxt); // RULE_26
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fill_r <= '0;
    end else if (accept && fill_r != vd_pkg::FILL_W'(vd_pkg::DELAY)) begin
      fill_r <= fill_r + vd_pkg::FILL_W'(1);
    end
  end

  // decoded output register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      m_tvalid_r <= 1'b0;
      m_tdata_r <= '0;
      m_tuser_r <= '0;
    end else if (i_clk_en) begin
      m_tvalid_r <= m_tvalid_nxt; // RULE_23
      if (emit) begin
        m_tdata_r <= '0;
        m_tdata_r[0] <= dly.dout[vd_pkg::W_BIT]; // RULE_15
        if (mode == vd_pkg::MODE_TRELLIS) begin
          m_tdata_r[vd_pkg::OUT_SECTOR_LSB +: vd_pkg::SECTOR_W] <=
            dly.dout[vd_pkg::W_SECT +: vd_pkg::SECTOR_W]; // RULE_08
        end
        m_tuser_r <= '0; // RULE_17
        m_tuser_r[vd_pkg::TO_SEL] <= dly.dout[vd_pkg::W_SEL]; // RULE_18
        m_tuser_r[vd_pkg::TO_BLOCK] <= dly.dout[vd_pkg::W_BLK]; // RULE_13
        m_tuser_r[vd_pkg::TO_METRIC_RENORM_FLAG] <= ctrl_r[vd_pkg::C_METRIC_RENORM_FLAG] &&
          (metric_renorm_flag_pend_r || renorm); // RULE_19
      end
    end
  end

  // renorm pending until carried out; an event on an emitting transfer goes into that word, not pending
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      metric_renorm_flag_pend_r <= 1'b0;
    end else if (renorm && !emit) begin
      metric_renorm_flag_pend_r <= 1'b1;
    end else if (emit) begin
      metric_renorm_flag_pend_r <= 1'b0;
    end
  end

  // per-channel path metric with normalization
  generate
    for (g = 0; g < vd_pkg::MAX_CH; g = g + 1) begin : gen_metric
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          metric_r[g] <= '0;
        end else if (accept && ch_r == vd_pkg::CH_W'(g)) begin
          metric_r[g] <= renorm ? metric_sum - vd_pkg::RENORM_LIMIT :
            metric_sum; // RULE_19
        end
      end
    end
  endgenerate

  // interleaved channel index
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ch_r <= '0;
    end else if (mode != vd_pkg::MODE_MULTI) begin
      ch_r <= '0;
    end else if (accept) begin
      ch_r <= (ch_r >= ctrl_r[vd_pkg::C_CH_LSB +: vd_pkg::CH_W]) ?
        '0 : ch_r + vd_pkg::CH_W'(1); // RULE_22
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      renorm_cnt_r <= '0;
    end else if (renorm) begin
      renorm_cnt_r <= renorm_cnt_r + 32'h00000001;
    end
  end

  // re-encode output bit against delayed hard symbols
  assign mism = dly.dout[vd_pkg::W_ACT +: R] &
    (dly.dout[vd_pkg::W_HARD +: R] ^ {R{dly.dout[vd_pkg::W_BIT]}});
  always_comb begin
    errs = 2'h0;
    for (int i = 0; i < R; i++) begin
      errs = errs + {1'b0, mism[i]};
    end
  end
  assign error_count_report.sym = emit && (mode != vd_pkg::MODE_TRELLIS); // RULE_21
  assign error_count_report.errs = errs;
  assign error_count_report.s_valid = i_clk_en && i_s_dstat_tvalid; // RULE_20
  assign error_count_report.s_data = i_s_dstat_tdata;
  assign error_count_report.m_ready = i_clk_en && i_m_dstat_tready; // RULE_24

  // apb slave, one wait state
  assign apb_acc = i_psel && i_penable && pready_r;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= i_psel && i_penable && !pready_r;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      if (i_psel && i_penable && !pready_r) begin
        case (i_paddr)
          vd_pkg::REG_CTRL: begin
            prdata_r <= {19'h00000, ctrl_r};
          end
          vd_pkg::REG_STATUS: begin
            prdata_r <= {19'h00000, ch_r, 4'h0, o_m_dstat_tvalid,
              m_tvalid_r, s_tready_r, life_r == vd_pkg::LIFE_RUN};
          end
          vd_pkg::REG_RENORM: begin
            prdata_r <= renorm_cnt_r;
          end
          default: begin
            pslverr_r <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= vd_pkg::CTRL_RST;
    end else if (apb_acc && i_pwrite && i_paddr == vd_pkg::REG_CTRL) begin
      ctrl_r <= i_pwdata[vd_pkg::CTRL_W-1:0];
    end
  end

  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_prdata = prdata_r;
  assign o_s_data_tready = s_tready_r;
  assign o_m_data_tvalid = m_tvalid_r;
  assign o_m_data_tdata = m_tdata_r; // RULE_16
  assign o_m_data_tuser = m_tuser_r; // RULE_14
  assign o_s_dstat_tready = error_count_report.s_ready;
  assign o_m_dstat_tvalid = error_count_report.m_valid;
  assign o_m_dstat_tdata = error_count_report.m_data;
endmodule
`default_nettype wire

// ### tb/vd_stream_ports_assertions.sv
// concurrent checks on the decoder stream port pins
`timescale 1ns/100ps
`default_nettype none
module vd_stream_ports_assertions (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // streams
  input wire logic o_s_data_tready,
  input wire logic o_m_data_tvalid,
  input wire logic i_m_data_tready,
  input wire logic [15:0] o_m_data_tdata,
  input wire logic [7:0] o_m_data_tuser,
  input wire logic o_m_dstat_tvalid,
  input wire logic i_m_dstat_tready,
  input wire logic [15:0] o_m_dstat_tdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_apb_one_wait: assert property (i_psel && i_penable && !o_pready
    |=> o_pready) else $error("apb answer not after one wait");
  a_idle_rdata: assert property (!o_pready
    |-> o_prdata == 32'h0 && !o_pslverr) else $error("apb idle data");
  a_data_hold: assert property (o_m_data_tvalid && !(i_m_data_tready &&
    i_clk_en) |=> o_m_data_tvalid && $stable(o_m_data_tdata) &&
    $stable(o_m_data_tuser)) else $error("data word not held");
  a_report_hold: assert property (o_m_dstat_tvalid && !(i_m_dstat_tready
    && i_clk_en) |=> o_m_dstat_tvalid && $stable(o_m_dstat_tdata))
    else $error("report not held");
  a_freeze_state: assert property (!i_clk_en |=> $stable(o_s_data_tready)
    && $stable(o_m_data_tvalid) && $stable(o_m_dstat_tvalid))
    else $error("state moved while disabled");
  a_ready_early: assert property ($fell(i_reset)
    |-> !o_s_data_tready [*2]) else $error("ready too soon");
  a_ready_start: assert property ($fell(i_reset) ##0 i_clk_en [*2]
    |=> o_s_data_tready) else $error("ready too late");
  a_one_bit_out: assert property (o_m_data_tvalid
    |-> o_m_data_tdata[7:1] == 7'h0 && o_m_data_tdata[15:12] == 4'h0)
    else $error("output word spare bits set");
endmodule
bind vd_stream_ports vd_stream_ports_assertions chk_u (.i_clk, .i_reset,
  .i_clk_en, .i_psel, .i_penable, .o_pready, .o_prdata, .o_pslverr,
  .o_s_data_tready, .o_m_data_tvalid, .i_m_data_tready, .o_m_data_tdata,
  .o_m_data_tuser, .o_m_dstat_tvalid, .i_m_dstat_tready, .o_m_dstat_tdata);
`default_nettype wire

// ### tb/stream_sink.sv
// downstream consumer model for the decoded and report streams
`timescale 1ns/100ps
`default_nettype none
module stream_sink (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // stall controls
  input wire logic i_slow,
  input wire logic i_hold,
  input wire logic i_dhold,
  // ready lines
  output logic o_m_ready,
  output logic o_d_ready
);
  logic tog_r;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
    end
  end
  // slow mode accepts every other cycle
  assign o_m_ready = !i_hold && (!i_slow || tog_r);
  assign o_d_ready = !i_dhold;
endmodule
`default_nettype wire

// ### tb/test_conv_decoder_stream_ports.sv
// self-checking bench for the decoder stream ports
`timescale 1ns/100ps
`default_nettype none
module test_conv_decoder_stream_ports;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, s_ready, m_valid, m_ready, w_ready;
  logic r_valid, r_ready;
  logic [31:0] prdata;
  logic s_valid = 1'b0;
  logic [39:0] s_data = 40'h0;
  logic [7:0] s_user = 8'h0;
  logic [15:0] m_data, r_data;
  logic [7:0] m_user;
  logic w_valid = 1'b0;
  logic [15:0] w_data = 16'h0;
  logic slow = 1'b0;
  logic hold = 1'b0;
  logic dhold = 1'b0;
  logic [23:0] q[$];
  int n_mismatch = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  vd_stream_ports dut (.i_clk(clk), .i_reset(reset), .i_clk_en(clk_en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_s_data_tvalid(s_valid),
    .o_s_data_tready(s_ready), .i_s_data_tdata(s_data),
    .i_s_data_tuser(s_user), .o_m_data_tvalid(m_valid),
    .i_m_data_tready(m_ready), .o_m_data_tdata(m_data),
    .o_m_data_tuser(m_user), .i_s_dstat_tvalid(w_valid),
    .o_s_dstat_tready(w_ready), .i_s_dstat_tdata(w_data),
    .o_m_dstat_tvalid(r_valid), .i_m_dstat_tready(r_ready),
    .o_m_dstat_tdata(r_data));
  stream_sink sink (.i_clk(clk), .i_reset(reset), .i_slow(slow),
    .i_hold(hold), .i_dhold(dhold), .o_m_ready(m_ready),
    .o_d_ready(r_ready));
  // words taken at the coming rising edge
  always @(negedge clk) begin
    if (!reset && clk_en && m_valid && m_ready) begin
      q.push_back({m_user, m_data});
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [39:0] d, input logic [7:0] u);
    @(posedge clk);
    s_valid <= 1'b1;
    s_data <= d;
    s_user <= u;
    do @(negedge clk); while (!(s_ready === 1'b1 && clk_en));
    @(posedge clk);
    s_valid <= 1'b0;
  endtask
  // all lanes carry b unless inverted, fill bits set to ones
  function automatic logic [39:0] word(input logic b, input logic [2:0] v);
    word = {16'hffff, 5'h1f, {3{b ^ v[2]}}, 5'h1f, {3{b ^ v[1]}},
      5'h1f, {3{b ^ v[0]}}};
  endfunction
  task automatic do_reset();
    int n;
    n = 0;
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    q.delete();
    do begin
      @(negedge clk);
      n++;
    end while (s_ready !== 1'b1 && n < 9);
    chk(n, 3, "ready delay");
  endtask
  task automatic test_regs();
    logic [31:0] r;
    logic e;
    do_reset();
    apb(1'b0, vd_pkg::REG_CTRL, 32'h0, r, e);
    chk(r, {19'h0, vd_pkg::CTRL_RST}, "ctrl reset");
    apb(1'b0, vd_pkg::REG_STATUS, 32'h0, r, e);
    chk(r, 32'h3, "status");
    apb(1'b1, vd_pkg::REG_CTRL, 32'h1f55, r, e);
    apb(1'b0, vd_pkg::REG_CTRL, 32'h0, r, e);
    chk(r, 32'h1f55, "ctrl rw");
    apb(1'b0, 12'h00c, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000, "unmapped");
    $display("regs done");
  endtask
  task automatic test_stream();
    logic [31:0] r;
    logic e;
    logic [7:0] bits;
    logic [2:0] v;
    bits = 8'hb2;
    do_reset();
    apb(1'b1, vd_pkg::REG_CTRL, 32'h32, r, e);
    slow <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      v = (k == 5) ? 3'h5 : (k == 6) ? 3'h2 : 3'h0;
      send(word(bits[k % 8], v), {3'h0, k == 3, k[1], v & 3'h3});
    end
    repeat (40) @(posedge clk);
    chk(q.size(), 8, "count");
    for (int k = 0; k < 8; k++) begin
      chk(q[k], {5'h0, k == 3, k[1], 15'h0, bits[k]}, "word");
      chk(q[k][16], k[1], "sel");
      chk(q[k][0], bits[k], "bit");
    end
    slow <= 1'b0;
    $display("stream done");
  endtask
  task automatic test_trellis();
    do_reset();
    for (int k = 0; k < 12; k++) send({4'h0, 4'(k), 32'h0}, 8'h0);
    repeat (10) @(posedge clk);
    chk(q.size(), 4, "trellis count");
    for (int k = 0; k < 4; k++) chk(q[k][15:8], k, "sector");
    $display("trellis done");
  endtask
  task automatic test_freeze();
    logic [31:0] r;
    logic e;
    do_reset();
    apb(1'b1, vd_pkg::REG_CTRL, 32'h0, r, e);
    hold <= 1'b1;
    for (int k = 0; k < 9; k++) send(word(k == 0, 3'h0), 8'h0);
    @(posedge clk);
    clk_en <= 1'b0;
    hold <= 1'b0;
    repeat (5) @(posedge clk);
    chk(q.size(), 0, "frozen take");
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk(q.size(), 1, "resumed take");
    chk(q[0], 24'h1, "first bit");
    $display("freeze done");
  endtask
  task automatic test_report();
    logic [31:0] r;
    logic e;
    logic [15:0] v;
    int n;
    do_reset();
    apb(1'b1, vd_pkg::REG_CTRL, 32'h0, r, e);
    w_valid <= 1'b1;
    w_data <= 16'h0004;
    @(posedge clk);
    w_valid <= 1'b0;
    dhold <= 1'b1;
    for (int k = 0; k < 16; k++)
      send(word(k[0], {2'h0, k == 1}), 8'h0);
    n = 0;
    while (r_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    v = r_data;
    repeat (10) @(negedge clk);
    chk({r_valid, r_data}, {1'b1, v}, "held report");
    chk(v, 32'h1, "error count");
    dhold <= 1'b0;
    $display("report done");
  endtask
  initial begin
    test_regs();
    test_stream();
    test_trellis();
    test_freeze();
    test_report();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
